// [logic/link_shifter.sv]
// Serial-clock side: arming, bit capture, staging bank and chained output.
// Assumes the serial clock is gated by the host and may stand still between frames.
`timescale 1ns/100ps
module link_shifter
    import xpt_pkg::*;
(
    input  wire logic sclk,
    input  wire logic rst_n,
    input  wire logic cs_n,
    input  wire logic din,
    input  wire logic mode,
    output logic      dout,
    stage_if.link     stg
);
    logic                  armed_ff;
    logic                  fresh_ff;
    logic                  mode_ff;
    logic                  dout_ff;
    logic [FRAME_BITS-1:0] stage_ff;
    logic [ADDR_BITS-1:0]  adr_ff;
    logic [CNT_W-1:0]      cnt_ff;
    logic                  tgl_ff;

    wire                  capture  = armed_ff & ~cs_n;
    wire [CNT_W-1:0]      bit_idx  = fresh_ff ? '0 : cnt_ff;
    wire [ADDR_BITS-1:0]  adr_word = {din, adr_ff[ADDR_BITS-1:1]};
    wire [1:0]            tgt      = adr_word[ADR_OUT_LSB +: 2];
    wire                  adr_done = mode_ff & (bit_idx == ADR_LAST_IDX);
    wire                  ser_shift = ~mode_ff;

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
            fresh_ff <= 1'b0;
            mode_ff  <= 1'b0;
        end else begin
            armed_ff <= ~cs_n;
            fresh_ff <= ~cs_n & ~armed_ff;
            // Mode is a level held by the host for the whole frame
            if (~cs_n & ~armed_ff) begin
                mode_ff <= mode;
            end
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'b0;
        end else begin
            dout_ff <= stage_ff[0];
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_ff <= STAGE_RESET;
            adr_ff   <= '0;
            cnt_ff   <= '0;
            tgl_ff   <= 1'b0;
        end else if (capture) begin
            adr_ff <= adr_word;
            cnt_ff <= (bit_idx == CNT_MAX) ? CNT_MAX : bit_idx + 3'h1;
            if (ser_shift) begin
                stage_ff <= {din, stage_ff[FRAME_BITS-1:1]};
                tgl_ff   <= ~tgl_ff;
            end else if (adr_done) begin
                stage_ff[tgt*GRP_W +: GRP_W] <= {adr_word[ADR_OFF_POS],
                                                 adr_word[ADR_SEL_LSB +: SEL_W]};
                tgl_ff   <= ~tgl_ff;
            end
        end
    end

    assign dout        = dout_ff;
    assign stg.stage   = stage_ff;
    assign stg.new_tgl = tgl_ff;

    chk_dout_tail_bit: assert property (@(posedge sclk) disable iff (!rst_n)
        (stage_ff[0] |=> dout_ff) and (!stage_ff[0] |=> !dout_ff))
        else $error("serial output does not follow staging tail");

    chk_idle_no_shift: assert property (@(negedge sclk) disable iff (!rst_n)
        !capture |=> $stable(stage_ff))
        else $error("staging bank moved while unselected");

    chk_serial_shift_in: assert property (@(negedge sclk) disable iff (!rst_n)
        capture && !mode_ff |=> stage_ff == {$past(din), $past(stage_ff[FRAME_BITS-1:1])})
        else $error("serial frame bit not shifted in");

    chk_addr_one_group: assert property (@(negedge sclk) disable iff (!rst_n)
        capture && mode_ff && !adr_done |=> $stable(stage_ff))
        else $error("addressed frame changed staging before its last bit");
endmodule

// [logic/sync2.sv]
// Two-flip-flop level synchroniser, one per bit.
// Assumes inputs are levels that stay put for several destination cycles.
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// [logic/xpt_config_top.sv]
// Configuration logic of an 8-input, 4-output crosspoint switch.
// Assumes a host drives select, serial clock and data; the matrix reads the outputs.
//
// Behaviour
// - Active per-output select and off registers
// - Staging bank shaped alike, loaded serially
// - Select low active; high ignores clock, data
// - First rising edge arms; falling edges capture
// - Matrix changes only on apply strobe, reset pin or broadcast pin
// - Apply works whatever select level
// - No new bits: apply changes nothing
// - Mode high: addressed frame updates one output
// - Mode low: sixteen-bit frame sets all
// - Mode and apply sampled as levels
// - Full frame: four groups, select then off
// - Addressed: output, select, off bit order
// - Reset pin: all outputs off, input zero
// - Broadcast pin: all outputs on, input zero
`timescale 1ns/100ps
module xpt_config_top
    import xpt_pkg::*;
(
    input  wire logic                     CLK_SYS,
    input  wire logic                     RSTN,
    input  wire logic                     SCLK,
    input  wire logic                     CS_N,
    input  wire logic                     DIN,
    output logic                          DOUT,
    input  wire logic                     CFG,
    input  wire logic                     MODE,
    input  wire logic                     RST,
    input  wire logic                     BROADCAST_ALL,
    output logic [NUM_OUT*SEL_W-1:0]      SEL_OUT,
    output logic [NUM_OUT-1:0]            OUT_EN,
    output logic                          PENDING
);

    function automatic logic [SEL_W-1:0] grp_sel(input logic [FRAME_BITS-1:0] bank,
                                                 input int                    k);
        grp_sel = bank[k*GRP_W + GRP_SEL_LSB +: SEL_W];
    endfunction

    function automatic logic grp_off(input logic [FRAME_BITS-1:0] bank,
                                     input int                    k);
        grp_off = bank[k*GRP_W + GRP_OFF_POS];
    endfunction

    logic                       rst_meta_ff;
    logic                       rst_n_ff;
    logic [3:0]                 pin_s;
    logic                       tgl_s;
    logic                       tgl_d_ff;
    logic                       cfg_d_ff;
    logic                       dirty_ff;
    logic [FRAME_BITS-1:0]      snap_ff;
    logic [NUM_OUT*SEL_W-1:0]   sel_ff;
    logic [NUM_OUT-1:0]         off_ff;
    logic [NUM_OUT*SEL_W-1:0]   snap_sel;
    logic [NUM_OUT-1:0]         snap_off;
    logic [NUM_OUT*SEL_W-1:0]   nxt_sel;
    logic [NUM_OUT-1:0]         nxt_off;
    logic                       nxt_dirty;

    stage_if stg ();

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    link_shifter u_link (
        .sclk  (SCLK),
        .rst_n (rst_n_ff),
        .cs_n  (CS_N),
        .din   (DIN),
        .mode  (MODE),
        .dout  (DOUT),
        .stg   (stg.link)
    );

    sync2 #(.W(4)) u_pin_sync (
        .clk   (CLK_SYS),
        .rst_n (rst_n_ff),
        .d     ({CFG, RST, BROADCAST_ALL, stg.new_tgl}),
        .q     (pin_s)
    );

    wire cfg_s    = pin_s[3];
    wire rst_s    = pin_s[2];
    wire all_on_s = pin_s[1];
    assign tgl_s  = pin_s[0];

    wire tgl_evt  = tgl_s ^ tgl_d_ff;
    wire cfg_rise = cfg_s & ~cfg_d_ff;

    // apply needs fresh bits, not select
    wire apply    = cfg_rise & dirty_ff;

    always_comb begin
        snap_sel = '0;
        snap_off = '0;
        for (int k = 0; k < NUM_OUT; k++) begin
            snap_sel[k*SEL_W +: SEL_W] = grp_sel(snap_ff, k);
            snap_off[k]                = grp_off(snap_ff, k);
        end
    end

    always_comb begin
        nxt_sel = sel_ff;
        nxt_off = off_ff;
        if (rst_s) begin
            nxt_sel = SEL_RESET;
            nxt_off = OFF_RESET;
        end else if (all_on_s) begin
            nxt_sel = {NUM_OUT{BROADCAST_INPUT}};
            nxt_off = OFF_NONE;
        end else if (apply) begin
            nxt_sel = snap_sel;
            nxt_off = snap_off;
        end
    end

    // new bits set pending; set wins over clear
    assign nxt_dirty = tgl_evt | (dirty_ff & ~apply);

    // Staging words are quiet once the host stops the clock, so the last
    // toggle always snapshots a settled bank; mid-frame snapshots are refreshed.
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tgl_d_ff <= 1'b0;
            cfg_d_ff <= 1'b0;
            dirty_ff <= 1'b0;
            snap_ff  <= STAGE_RESET;
        end else begin
            tgl_d_ff <= tgl_s;
            cfg_d_ff <= cfg_s;
            dirty_ff <= nxt_dirty;
            if (tgl_evt) begin
                snap_ff <= stg.stage;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sel_ff <= SEL_RESET;
            off_ff <= OFF_RESET;
        end else begin
            sel_ff <= nxt_sel;
            off_ff <= nxt_off;
        end
    end

    assign SEL_OUT = sel_ff;
    assign OUT_EN  = ~off_ff;
    assign PENDING = dirty_ff;

    chk_rst_forces_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        rst_s |=> off_ff == OFF_RESET && sel_ff == SEL_RESET)
        else $error("reset pin did not disable all outputs");

    chk_broadcast_all_on: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        all_on_s && !rst_s |=> off_ff == OFF_NONE && sel_ff == {NUM_OUT{BROADCAST_INPUT}})
        else $error("broadcast did not enable all outputs on input zero");

    chk_hold_no_apply: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        !apply && !rst_s && !all_on_s |=> $stable(sel_ff) && $stable(off_ff))
        else $error("matrix changed without apply strobe");

    chk_apply_copies_bank: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        apply && !rst_s && !all_on_s |=> sel_ff == $past(snap_sel) && off_ff == $past(snap_off))
        else $error("apply strobe did not copy staged settings");

    chk_clean_no_effect: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        cfg_rise && !dirty_ff && !rst_s && !all_on_s |=> $stable(sel_ff) && $stable(off_ff))
        else $error("repeat apply altered configuration");

    chk_cfg_any_select: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        cfg_rise && dirty_ff && !tgl_evt |=> !dirty_ff)
        else $error("apply strobe lost with fresh bits");

    chk_new_bits_pend: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        tgl_evt |=> dirty_ff && snap_ff == $past(stg.stage))
        else $error("new staged bits not marked pending");

    chk_pend_clears: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        apply && !tgl_evt |=> !dirty_ff ##1 (!cfg_rise || !apply))
        else $error("pending flag not cleared by apply");

    chk_cfg_level: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
        cfg_s ##1 cfg_s |-> !cfg_rise)
        else $error("held apply level seen as new strobe");
endmodule

// [pkg/stage_if.sv]
// Carries the staging bank and its change toggle from the serial-clock side.
// Assumes the link side drives it and the system side only reads it.
`timescale 1ns/100ps
interface stage_if;
    import xpt_pkg::*;

    logic [FRAME_BITS-1:0] stage;
    logic                  new_tgl;

    modport link (output stage, output new_tgl);
    modport sys  (input stage, input new_tgl);
endinterface

// [pkg/xpt_pkg.sv]
// Constants shared by the crosspoint configuration logic.
// Assumes an 8-input, 4-output matrix steered by per-output select and off flags.
package xpt_pkg;

    localparam int NUM_OUT      = 4;
    localparam int SEL_W        = 3;
    localparam int GRP_W        = 4;
    localparam int FRAME_BITS   = 16;
    localparam int ADDR_BITS    = 6;
    localparam int CNT_W        = 3;

    // Field positions inside one four-bit group of the staging bank
    localparam int GRP_SEL_LSB  = 0;
    localparam int GRP_OFF_POS  = 3;

    // Field positions inside the six-bit addressed frame
    localparam int ADR_OUT_LSB  = 0;
    localparam int ADR_SEL_LSB  = 2;
    localparam int ADR_OFF_POS  = 5;
    localparam logic [CNT_W-1:0] ADR_LAST_IDX = 3'h5;
    localparam logic [CNT_W-1:0] CNT_MAX      = 3'h7;

    // Values after reset and for broadcast
    localparam logic [FRAME_BITS-1:0]    STAGE_RESET = 16'h8888;
    localparam logic [NUM_OUT*SEL_W-1:0] SEL_RESET   = 12'h000;
    localparam logic [NUM_OUT-1:0]       OFF_RESET   = 4'hF;
    localparam logic [NUM_OUT-1:0]       OFF_NONE    = 4'h0;
    localparam logic [SEL_W-1:0]         BROADCAST_INPUT = 3'h0;

    localparam int SYNC_STAGES  = 2;

endpackage

// [test/host_model.sv]
// Host side of the serial link: gated serial clock, select and data.
// Assumes the bench calls its tasks one at a time; the clock stands still between frames.
`timescale 1ns/100ps
module host_model (
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // select low first, n pulses, bit 0 first
    task automatic frame(input logic [15:0] bits, input int n);
        cs_n = 1'b0;
        #7.5;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            #3 din = bits[i];
            #4.5 sclk = 1'b0;
            #7.5;
        end
        cs_n = 1'b1;
        din  = ~din;
        #7.5;
    endtask

    // one pulse with select high disarms; toggling data must be ignored
    task automatic idle_pulse();
        sclk = 1'b1;
        #3 din = ~din;
        #4.5 sclk = 1'b0;
        din = ~din;
        #7.5;
    endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the crosspoint configuration logic.
// Assumes the host model drives the serial link at a 15 ns bit time.
`timescale 1ns/100ps
module tb;
    import xpt_pkg::*;
    logic                     clk_sys = 1'b0;
    logic                     rstn    = 1'b0;
    logic                     cfg     = 1'b0;
    logic                     mode    = 1'b0;
    logic                     rst     = 1'b0;
    logic                     broadcast_all = 1'b0;
    logic                     sclk;
    logic                     cs_n;
    logic                     din;
    logic                     dout;
    logic [NUM_OUT*SEL_W-1:0] sel_out;
    logic [NUM_OUT-1:0]       out_en;
    logic                     pending;
    int                       fail_count = 0;
    int                       checked    = 0;

    always #4 clk_sys = ~clk_sys;

    host_model i_host_model (.sclk(sclk), .cs_n(cs_n), .din(din));

    xpt_config_top i_xpt_config_top (
        .CLK_SYS(clk_sys), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .DOUT(dout), .CFG(cfg), .MODE(mode), .RST(rst), .BROADCAST_ALL(broadcast_all),
        .SEL_OUT(sel_out), .OUT_EN(out_en), .PENDING(pending)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_sys(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Strobe held long enough for the synchroniser; select stays high meanwhile
    task automatic apply();
        wait_sys(1);
        cfg <= 1'b1;
        wait_sys(4);
        cfg <= 1'b0;
        wait_sys(4);
    endtask

    task automatic t_reset_values();
        check(sel_out, 16'h0000);
        check(out_en, 16'h0000);
        check(pending, 16'h0000);
    endtask

    // stage first, apply later
    // Full frame: staged only, then applied with select high
    task automatic t_full_frame();
        i_host_model.frame(16'h17A5, 16);
        i_host_model.idle_pulse();
        wait_sys(6);
        check(pending, 16'h0001);
        check(sel_out, 16'h0000);
        check(out_en, 16'h0000);
        check(dout, 16'h0001);
        apply();
        check(sel_out, 16'h03D5);
        check(out_en, 16'h000D);
        check(pending, 16'h0000);
    endtask

    // Reset pin, then a strobe with nothing new staged
    task automatic t_reset_then_apply();
        wait_sys(1);
        rst <= 1'b1;
        wait_sys(5);
        check(sel_out, 16'h0000);
        check(out_en, 16'h0000);
        rst <= 1'b0;
        wait_sys(4);
        apply();
        check(out_en, 16'h0000);
    endtask

    task automatic t_broadcast();
        wait_sys(1);
        broadcast_all <= 1'b1;
        wait_sys(5);
        check(sel_out, 16'h0000);
        check(out_en, 16'h000F);
        broadcast_all <= 1'b0;
        wait_sys(4);
        check(out_en, 16'h000F);
    endtask

    // Addressed frame: output 2 gets input 3, on; other groups keep staged values
    task automatic t_addressed();
        wait_sys(1);
        mode <= 1'b1;
        wait_sys(2);
        i_host_model.frame(16'h000E, 6);
        i_host_model.idle_pulse();
        wait_sys(6);
        check(pending, 16'h0001);
        check(out_en, 16'h000F);
        apply();
        check(sel_out, 16'h02D5);
        check(out_en, 16'h000D);
        mode <= 1'b0;
    endtask

    // apply after select: strobe rises four system cycles after the frame task returns, which is 32.5 ns after select goes high
    task automatic t_three_wire();
        wait_sys(1);
        cfg <= 1'b0;
        i_host_model.frame(16'h0000, 16);
        wait_sys(4);
        cfg <= 1'b1;
        wait_sys(6);
        check(sel_out, 16'h0000);
        check(out_en, 16'h000F);
        check(pending, 16'h0000);
        cfg <= 1'b0;
        wait_sys(4);
    endtask

    // Activity while select is high must stage nothing
    task automatic t_select_high();
        i_host_model.idle_pulse();
        i_host_model.idle_pulse();
        wait_sys(6);
        check(pending, 16'h0000);
    endtask

    initial begin
        wait_sys(3);
        rstn <= 1'b1;
        wait_sys(6);
        t_reset_values();
        t_full_frame();
        t_reset_then_apply();
        t_broadcast();
        t_addressed();
        t_select_high();
        t_three_wire();
        tally_and_finish();
    end

    // Tests need well under two microseconds; this margin is ample
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
endmodule
